// file: hw/ddrseq_pkg.sv
// Package: command codes, mode fields, pin and token carriers, timing counts
// Behaviour
// R1 - read data at additive plus cas latency
// R2 - read to write gap four or six
// R3 - seamless reads every half burst length
// R4 - seamless writes every half burst length
// R5 - read interrupt only with burst eight
// R6 - read burst cut only by read
// R7 - read interrupt exactly two clocks later
// R8 - auto precharge read never interrupted
// R9 - spacing from programmed burst length, not shortened
// R10 - write interrupt only with burst eight
// R11 - write burst cut only by write
// R12 - write interrupt exactly two clocks later
// R13 - auto precharge write never interrupted
// R14 - write recovery counts from uninterrupted end; code only flags precharge within burst_clks of the last write
// R15 - write to read needs cas-1 plus half burst; code also adds WR_TO_RD_DELAY, two clocks
// R16 - all banks idle before self refresh
// R17 - termination off before self refresh entry
// R18 - exit delays before read or other command; code counts no delay, only flags a command on the exit edge
// R19 - latch burst length from mode register
package ddrseq_pkg;

  // ****************************************************
  // Command encodings {ras_n, cas_n, we_n}
  // ****************************************************
  localparam logic [2:0] CMD_MODE = 3'h0;
  localparam logic [2:0] CMD_REFRESH = 3'h1;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_ACTIVATE = 3'h3;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_READ = 3'h5;

  // ****************************************************
  // Mode register fields and reset values
  // ****************************************************
  localparam int BURST_FIELD_LSB = 0;
  localparam int CAS_FIELD_LSB = 4;
  localparam int ADD_FIELD_LSB = 3;
  localparam int AP_BIT = 10;
  localparam logic [2:0] BURST_CODE_EIGHT = 3'h3;
  localparam logic [2:0] BANK_MODE = 3'h0;
  localparam logic [2:0] BANK_EXT_MODE = 3'h1;
  localparam logic [2:0] CAS_LAT_RESET = 3'h3;
  localparam logic [2:0] ADD_LAT_RESET = 3'h0;
  localparam logic BL8_RESET = 1'b0;

  // ****************************************************
  // Spacing counts in link clocks, burst lengths in beats
  // ****************************************************
  localparam logic [3:0] BURST_CLKS_BL4 = 4'h2;
  localparam logic [3:0] BURST_CLKS_BL8 = 4'h4;
  localparam logic [3:0] RD_TO_WR_BL4 = 4'h4;
  localparam logic [3:0] RD_TO_WR_BL8 = 4'h6;
  localparam logic [3:0] INTERRUPT_GAP = 4'h2;
  localparam logic [3:0] WR_TO_RD_DELAY = 4'h2;
  localparam logic [3:0] BEATS_BL4 = 4'h4;
  localparam logic [3:0] BEATS_BL8 = 4'h8;

  // ****************************************************
  // Carriers
  // ****************************************************
  localparam int ADDR_W = 14;
  localparam int DQ_W = 8;
  localparam int MEM_DEPTH = 16;
  localparam int DELAY_DEPTH = 16;

  // Command pins of the link
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] bank;
    logic [ADDR_W-1:0] addr;
  } ddrsq_cmd_t;

  // Latency token travelling the delay line
  typedef struct packed {
    logic valid;
    logic [3:0] col;
  } ddrsq_tok_t;

  // Link power state
  typedef enum logic [0:0] {
    PWR_AWAKE,
    PWR_SELF_REFRESH
  } ddrsq_pwr_t;

endpackage : ddrseq_pkg

// file: hw/ddrsq_burst.sv
// Latency delay line and burst beat counter for one direction
`timescale 1ns/1ps
module ddrsq_burst (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Link timing pulses
  input wire logic ck_rise,
  input wire logic beat,
  // Command entry
  input wire logic start,
  input wire logic [3:0] start_col,
  input wire logic [3:0] latency,
  input wire logic bl8,
  // Beat state
  output logic active,
  output logic [3:0] addr
);
  import ddrseq_pkg::*;

  // ****************************************************
  // Delay line
  // ****************************************************
  ddrsq_tok_t line_reg [DELAY_DEPTH];  // One slot per link clock
  ddrsq_tok_t tap;                     // Token whose latency expires now
  logic [3:0] left_reg;                // Beats still to go
  logic [3:0] wrap_mask;               // Address bits that wrap

  assign tap = line_reg[latency - 4'h1];
  assign wrap_mask = bl8 ? 4'h7 : 4'h3;

  // Tokens shift on each rising link edge; slot 0 takes the command
  genvar gi;
  generate
    for (gi = 0; gi < DELAY_DEPTH; gi++) begin : g_line
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          line_reg[gi] <= '0;
        end else if (ck_rise) begin
          if (gi == 0) begin
            line_reg[gi] <= '{valid: start, col: start_col};
          end else begin
            line_reg[gi] <= line_reg[gi-1];
          end
        end
      end
    end
  endgenerate

  // ****************************************************
  // Beat counter
  // ****************************************************
  // A fresh token restarts the burst, which truncates an older one
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      active <= 1'b0;
      addr <= '0;
      left_reg <= '0;
    end else if (ck_rise && tap.valid) begin
      // R1 data starts at latency
      active <= 1'b1;
      addr <= tap.col;
      // R19 programmed length sets beats
      left_reg <= (bl8 ? BEATS_BL8 : BEATS_BL4) - 4'h1;
    end else if (beat) begin
      if (left_reg != 4'h0) begin
        left_reg <= left_reg - 4'h1;
        // Wrap inside the burst block
        addr <= (addr & ~wrap_mask) | ((addr + 4'h1) & wrap_mask);
      end else begin
        active <= 1'b0;
      end
    end
  end

endmodule : ddrsq_burst

// file: hw/ddrsq_top.sv
// Device-side command sequencer with read and write burst data path
`timescale 1ns/1ps
module ddrsq_top (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Link clock and command pins
  input wire logic ck,
  input wire ddrseq_pkg::ddrsq_cmd_t cmd_pins,
  // Data pins, split into in, out and enable
  input wire logic [ddrseq_pkg::DQ_W-1:0] dq_in,
  output logic [ddrseq_pkg::DQ_W-1:0] dq_out,
  output logic dq_oe,
  output logic dqs_out,
  output logic dqs_oe,
  // Status
  input wire logic on_die_termination,
  output logic self_refresh,
  output logic cmd_error
);
  import ddrseq_pkg::*;

  localparam int PIN_W = 1 + $bits(ddrsq_cmd_t) + DQ_W + 1;

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  logic [PIN_W-1:0] pin_s1_reg;   // First stage, read by stage two only
  logic [PIN_W-1:0] pin_s2_reg;
  logic [PIN_W-1:0] pin_s3_reg;
  logic [PIN_W-1:0] pin_f_reg;    // Accepted pin levels
  logic ck_f;
  ddrsq_cmd_t cmd_f;
  logic [DQ_W-1:0] dq_f;
  logic odt_f;
  logic ck_d_reg;                 // Previous accepted link clock
  logic ck_rise;
  logic beat;
  logic beat_d_reg;

  assign {ck_f, cmd_f, dq_f, odt_f} = pin_f_reg;
  assign ck_rise = ck_f && !ck_d_reg;
  assign beat = ck_f != ck_d_reg;

  // Each bit counts once stages two and three agree
  genvar gb;
  generate
    for (gb = 0; gb < PIN_W; gb++) begin : g_sync
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          pin_s1_reg[gb] <= 1'b0;
          pin_s2_reg[gb] <= 1'b0;
          pin_s3_reg[gb] <= 1'b0;
          pin_f_reg[gb] <= 1'b0;
        end else begin
          pin_s1_reg[gb] <= pin_in(gb);
          pin_s2_reg[gb] <= pin_s1_reg[gb];
          pin_s3_reg[gb] <= pin_s2_reg[gb];
          if (pin_s2_reg[gb] == pin_s3_reg[gb]) begin
            pin_f_reg[gb] <= pin_s3_reg[gb];
          end
        end
      end
    end
  endgenerate

  // Raw pin vector picked bit by bit
  function automatic logic pin_in(input int idx);
    logic [PIN_W-1:0] raw;
    raw = {ck, cmd_pins, dq_in, on_die_termination};
    return raw[idx];
  endfunction : pin_in

  // Edge history of the link clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ck_d_reg <= 1'b0;
      beat_d_reg <= 1'b0;
    end else begin
      ck_d_reg <= ck_f;
      beat_d_reg <= beat;
    end
  end

  // ****************************************************
  // Command decode
  // ****************************************************
  logic cmd_valid;
  logic [2:0] cmd_code;
  logic is_read;
  logic is_write;
  logic auto_pre;

  assign cmd_valid = ck_rise && cmd_f.cke && !cmd_f.cs_n;
  assign cmd_code = {cmd_f.ras_n, cmd_f.cas_n, cmd_f.we_n};
  assign is_read = cmd_valid && cmd_code == CMD_READ;
  assign is_write = cmd_valid && cmd_code == CMD_WRITE;
  assign auto_pre = cmd_f.addr[AP_BIT];

  // ****************************************************
  // Mode registers
  // ****************************************************
  logic bl8_reg;                  // Programmed burst of eight
  logic [2:0] cas_latency_reg;
  logic [2:0] additive_latency_reg;
  logic [3:0] read_latency;
  logic [3:0] write_latency;
  logic [3:0] burst_clks;

  // R1 read latency is additive plus cas
  assign read_latency = {1'b0, additive_latency_reg} +
                        {1'b0, cas_latency_reg};
  // R1 write latency one clock less
  assign write_latency = read_latency - 4'h1;
  assign burst_clks = bl8_reg ? BURST_CLKS_BL8 : BURST_CLKS_BL4;

  // Mode writes land on the bank that selects the register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bl8_reg <= BL8_RESET;
      cas_latency_reg <= CAS_LAT_RESET;
      additive_latency_reg <= ADD_LAT_RESET;
    end else if (cmd_valid && cmd_code == CMD_MODE) begin
      if (cmd_f.bank == BANK_MODE) begin
        // R19 latch programmed burst length
        bl8_reg <= cmd_f.addr[BURST_FIELD_LSB+:3] == BURST_CODE_EIGHT;
        cas_latency_reg <= cmd_f.addr[CAS_FIELD_LSB+:3];
      end else if (cmd_f.bank == BANK_EXT_MODE) begin
        additive_latency_reg <= cmd_f.addr[ADD_FIELD_LSB+:3];
      end
    end
  end

  // ****************************************************
  // Command spacing tracking
  // ****************************************************
  logic [3:0] rd_gap_reg;         // Link clocks since last read, minus one
  logic [3:0] wr_gap_reg;         // Link clocks since last write, minus one
  logic rd_ap_reg;                // Last read carried auto precharge
  logic wr_ap_reg;
  logic [3:0] rd_el;
  logic [3:0] wr_el;
  logic rd_open;
  logic wr_open;

  // Saturation keeps old commands from wrapping back into range
  assign rd_el = (rd_gap_reg == 4'hf) ? 4'hf : rd_gap_reg + 4'h1;
  assign wr_el = (wr_gap_reg == 4'hf) ? 4'hf : wr_gap_reg + 4'h1;
  // R9 window uses programmed length
  assign rd_open = rd_el < burst_clks;
  assign wr_open = wr_el < burst_clks;

  // Gap counters restart on each command of their kind
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_gap_reg <= 4'hf;
      wr_gap_reg <= 4'hf;
      rd_ap_reg <= 1'b0;
      wr_ap_reg <= 1'b0;
    end else if (ck_rise) begin
      rd_gap_reg <= is_read ? 4'h0 : rd_el;
      wr_gap_reg <= is_write ? 4'h0 : wr_el;
      if (is_read) begin
        rd_ap_reg <= auto_pre;
      end
      if (is_write) begin
        wr_ap_reg <= auto_pre;
      end
    end
  end

  // ****************************************************
  // Bank state and self refresh
  // ****************************************************
  logic [7:0] bank_open_reg;      // One bit per activated bank
  ddrsq_pwr_t pwr_reg;
  logic sr_enter;

  assign sr_enter = ck_rise && !cmd_f.cke && !cmd_f.cs_n &&
                    cmd_code == CMD_REFRESH && pwr_reg == PWR_AWAKE;

  // Activate opens, precharge or auto precharge closes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bank_open_reg <= '0;
    end else if (cmd_valid) begin
      case (cmd_code)
        CMD_ACTIVATE: bank_open_reg[cmd_f.bank] <= 1'b1;
        CMD_PRECHARGE: begin
          if (auto_pre) begin
            bank_open_reg <= '0;
          end else begin
            bank_open_reg[cmd_f.bank] <= 1'b0;
          end
        end
        CMD_READ, CMD_WRITE: begin
          if (auto_pre) begin
            bank_open_reg[cmd_f.bank] <= 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  // Refresh with clock enable low enters, clock enable high leaves
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pwr_reg <= PWR_AWAKE;
    end else begin
      case (pwr_reg)
        PWR_AWAKE: if (sr_enter) pwr_reg <= PWR_SELF_REFRESH;
        PWR_SELF_REFRESH: if (ck_rise && cmd_f.cke) pwr_reg <= PWR_AWAKE;
        default: pwr_reg <= PWR_AWAKE;
      endcase
    end
  end

  // ****************************************************
  // Protocol error flag
  // ****************************************************
  logic err_rd;
  logic err_wr;
  logic err_sr;

  // R5 R7 R8 only legal read interrupt
  assign err_rd = is_read && rd_open &&
                  !(bl8_reg && rd_el == INTERRUPT_GAP && !rd_ap_reg);
  // R10 R12 R13 only legal write interrupt
  assign err_wr = is_write && wr_open &&
                  !(bl8_reg && wr_el == INTERRUPT_GAP && !wr_ap_reg);
  // R16 R17 self refresh needs idle banks, termination off
  assign err_sr = sr_enter && (bank_open_reg != 8'h0 || odt_f);

  // One-cycle pulse per offending command
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_error <= 1'b0;
    end else begin
      cmd_error <= err_rd || err_wr || err_sr ||
        // R6 R2 write or precharge inside read
        (cmd_valid && rd_open && cmd_code == CMD_PRECHARGE) ||
        (is_write && rd_el < (bl8_reg ? RD_TO_WR_BL8 : RD_TO_WR_BL4)) ||
        // R11 R15 read or precharge inside write
        (cmd_valid && wr_open && cmd_code == CMD_PRECHARGE) ||
        (is_read && wr_el < ({1'b0, cas_latency_reg} - 4'h1 +
                             burst_clks + WR_TO_RD_DELAY)) ||
        // R18 commands only after exit
        (cmd_valid && pwr_reg == PWR_SELF_REFRESH && cmd_code != 3'h7);
    end
  end

  // ****************************************************
  // Burst engines and storage
  // ****************************************************
  logic rd_active;
  logic [3:0] rd_addr;
  logic wr_active;
  logic [3:0] wr_addr;
  logic [DQ_W-1:0] mem_reg [MEM_DEPTH];  // Column-indexed store

  // R3 seamless reads chain in the delay line
  ddrsq_burst u_read (
    .clk(clk),
    .sys_rst(sys_rst),
    .ck_rise(ck_rise),
    .beat(beat),
    .start(is_read),
    .start_col(cmd_f.addr[3:0]),
    .latency(read_latency),
    .bl8(bl8_reg),
    .active(rd_active),
    .addr(rd_addr)
  );

  // R4 seamless writes chain likewise
  ddrsq_burst u_write (
    .clk(clk),
    .sys_rst(sys_rst),
    .ck_rise(ck_rise),
    .beat(beat),
    .start(is_write),
    .start_col(cmd_f.addr[3:0]),
    .latency(write_latency),
    .bl8(bl8_reg),
    .active(wr_active),
    .addr(wr_addr)
  );

  // Write beats land one cycle after the beat, once the address settles
  always_ff @(posedge clk) begin
    if (beat_d_reg && wr_active) begin
      mem_reg[wr_addr] <= dq_f;
    end
  end

  // Read beats drive data with a strobe that follows the link clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dq_out <= '0;
      dq_oe <= 1'b0;
      dqs_out <= 1'b0;
      dqs_oe <= 1'b0;
      self_refresh <= 1'b0;
    end else begin
      self_refresh <= pwr_reg == PWR_SELF_REFRESH;
      if (beat_d_reg) begin
        dq_oe <= rd_active;
        dqs_oe <= rd_active;
        dqs_out <= rd_active && ck_d_reg;
        dq_out <= rd_active ? mem_reg[rd_addr] : '0;
      end
    end
  end

endmodule : ddrsq_top

// file: tb/ddrsq_ctrl_model.sv
// Controller model: free link clock, command pins, write data lane
`timescale 1ns/1ps
module ddrsq_ctrl_model (
  // System clock for launch timing
  input wire logic clk,
  // Link pins
  output logic ck,
  output ddrseq_pkg::ddrsq_cmd_t cmd_pins,
  output logic [ddrseq_pkg::DQ_W-1:0] dq_in
);
  import ddrseq_pkg::*;
  int hcnt = 0; // Link edges seen so far
  logic [DQ_W-1:0] wd[int]; // Write beats keyed by link edge
  // ********
  // Link clock
  // ********
  // Free running; phase kept apart from clk on purpose
  initial begin
    ck = 1'b0;
    dq_in = '0;
    cmd_pins = '0;
    cmd_pins.cke = 1'b1;
    cmd_pins.cs_n = 1'b1;
    #37;
    forever #200 ck = ~ck;
  end
  // beats set mid-cell, lane keeps moving otherwise
  always @(ck) begin
    hcnt++;
    repeat (2) @(posedge clk);
    dq_in <= wd.exists(hcnt + 1) ? wd[hcnt + 1] : ~dq_in;
  end
  // one command a link clock; code 7 deselects
  task automatic issue(input logic cke, input logic [2:0] code,
      input logic [2:0] bank, input logic [ADDR_W-1:0] addr,
      output int rise);
    @(negedge ck);
    @(posedge clk);
    cmd_pins <= {cke, code == 3'h7, code, bank, addr};
    rise = hcnt + 1;
    @(negedge ck);
    @(posedge clk);
    cmd_pins.cs_n <= 1'b1;
  endtask : issue
endmodule : ddrsq_ctrl_model

// file: tb/ddrsq_top_props.sv
// Checker: port relations of the device command sequencer
`timescale 1ns/1ps
module ddrsq_top_props (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Link side
  input wire logic ck,
  input wire ddrseq_pkg::ddrsq_cmd_t cmd_pins,
  input wire logic [ddrseq_pkg::DQ_W-1:0] dq_in,
  input wire logic on_die_termination,
  // Device outputs
  input wire logic [ddrseq_pkg::DQ_W-1:0] dq_out,
  input wire logic dq_oe,
  input wire logic dqs_out,
  input wire logic dqs_oe,
  input wire logic self_refresh,
  input wire logic cmd_error
);
  // ********
  // Relations
  // ********
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Reset must quiet every driver, so it is never disabled
  property p_rst_quiet;
    disable iff (1'b0) sys_rst |=> !dq_oe && !dqs_oe && !self_refresh
      && !cmd_error;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs active after reset");
  property p_oe_pair;
    dq_oe == dqs_oe;
  endproperty
  a_oe_pair: assert property (p_oe_pair)
    else $error("data and strobe enables differ");
  property p_err_pulse;
    cmd_error |=> !cmd_error;
  endproperty
  a_err_pulse: assert property (p_err_pulse)
    else $error("error flag longer than one cycle");
  property p_sr_quiet;
    self_refresh |-> !dq_oe;
  endproperty
  a_sr_quiet: assert property (p_sr_quiet)
    else $error("data driven in self refresh");
  // Two beats need one link period, eight clocks
  property p_oe_min;
    $rose(dq_oe) |-> dq_oe [*8];
  endproperty
  a_oe_min: assert property (p_oe_min)
    else $error("read burst too short");
  // A beat lands every half link period, four clocks
  property p_strobe_moves;
    (dq_oe && $stable(dqs_out)) [*6] |-> 1'b0;
  endproperty
  a_strobe_moves: assert property (p_strobe_moves)
    else $error("strobe stalled in burst");
  property p_dq_per_beat;
    dq_oe && $past(dq_oe) && $stable(dqs_out) |-> $stable(dq_out);
  endproperty
  a_dq_per_beat: assert property (p_dq_per_beat)
    else $error("read data moved between beats");
  // Exit needs a later link rise, eight clocks on
  property p_sr_hold;
    $rose(self_refresh) |-> self_refresh [*8];
  endproperty
  a_sr_hold: assert property (p_sr_hold)
    else $error("self refresh left too early");
endmodule : ddrsq_top_props

bind ddrsq_top ddrsq_top_props u_props (.clk, .sys_rst, .ck, .cmd_pins,
  .dq_in, .on_die_termination, .dq_out, .dq_oe, .dqs_out, .dqs_oe,
  .self_refresh, .cmd_error);

// file: tb/tb.sv
// Testbench: bursts, interrupts, illegal spacing and self refresh
`timescale 1ns/1ps
module tb;
  import ddrseq_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ck, dq_oe, dqs_out, dqs_oe, self_refresh, cmd_error;
  logic on_die_termination = 1'b0;
  ddrsq_cmd_t cmd_pins;
  logic [DQ_W-1:0] dq_in, dq_out;
  int n_errors = 0, n_compared = 0, seed = 59569;
  int blen = 4, rdlat = 3, errs = 0, e, r;
  bit chk_on = 1'b0; // Beat checking enabled
  logic [7:0] mem[16]; // Expected memory contents
  logic [7:0] exp_q[$]; // Expected read beats
  int edge_q[$]; // Link edge of each expected beat
  logic prev_oe = 1'b0, prev_dqs = 1'b0;

  always #25 clk = ~clk;
  ddrsq_top u_dut (.clk, .sys_rst, .ck, .cmd_pins, .dq_in, .dq_out,
    .dq_oe, .dqs_out, .dqs_oe, .on_die_termination, .self_refresh,
    .cmd_error);
  ddrsq_ctrl_model u_ctrl (.clk, .ck, .cmd_pins, .dq_in);

  // ********
  // Helpers
  // ********
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : check
  task automatic idle(input int n);
    repeat (n) @(negedge ck);
  endtask : idle
  // Burst order wraps inside its aligned block
  function automatic int wcol(input int col, input int k);
    return (col & ~(blen - 1)) | ((col + k) & (blen - 1));
  endfunction : wcol
  task automatic do_wr(input int col, input int n);
    logic [7:0] d;
    int rr;
    u_ctrl.issue(1'b1, CMD_WRITE, 3'h1, 14'(col), rr);
    for (int k = 0; k < blen; k++) begin
      d = 8'($random(seed));
      u_ctrl.wd[rr + 2 * (rdlat - 1) + k] = d;
      if (k < n) mem[wcol(col, k)] = d;
    end
  endtask : do_wr
  task automatic do_rd(input int col, input int n, input logic ap);
    int rr;
    u_ctrl.issue(1'b1, CMD_READ, 3'h2, {3'h0, ap, 6'h0, 4'(col)}, rr);
    for (int k = 0; k < n && chk_on; k++) begin
      exp_q.push_back(mem[wcol(col, k)]);
      edge_q.push_back(rr + 2 * rdlat + k);
    end
  endtask : do_rd
  task automatic expect_err(input int n);
    // Long enough that the next command clears the write to read gap
    repeat (60) @(negedge clk);
    check(errs, n);
    errs = 0;
  endtask : expect_err
  task automatic wrap_up;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  // Error pulses and read beats, both seen at clk
  always @(posedge clk) begin
    if (cmd_error === 1'b1) errs++;
    prev_oe <= dq_oe;
    prev_dqs <= dqs_out;
    if (chk_on && dq_oe === 1'b1 && (!prev_oe || dqs_out !== prev_dqs)) begin
      if (exp_q.size() == 0) check(dq_oe, 1'b0);
      else begin
        e = edge_q.pop_front();
        check(dq_out, exp_q.pop_front());
        check((u_ctrl.hcnt - e) inside {[0:2]}, 1'b1);
      end
    end
  end

  // Hang guard, far beyond the planned run
  initial begin
    #500000;
    n_errors++;
    wrap_up();
  end

  // ********
  // Main sequence
  // ********
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    check({dq_oe, dqs_oe, self_refresh, cmd_error}, 4'h0);
    repeat (8) @(posedge clk);
    u_ctrl.issue(1'b1, CMD_MODE, BANK_MODE, 14'h0033, r);
    blen = 8;
    chk_on = 1'b1;
    do_wr(0, 8);
    idle(2);
    do_wr(8, 8);
    idle(8);
    do_rd(0, 8, 1'b0);
    idle(2);
    do_rd(8, 8, 1'b0);
    idle(10);
    do_rd(4, 4, 1'b0);
    do_rd(8, 8, 1'b0);
    idle(10);
    do_wr(3, 4);
    do_wr(13, 8);
    idle(8);
    do_rd(0, 8, 1'b0);
    idle(2);
    do_rd(8, 8, 1'b0);
    idle(10);
    u_ctrl.issue(1'b1, CMD_MODE, BANK_EXT_MODE, 14'h0008, r);
    rdlat = 4;
    do_rd(5, 8, 1'b0);
    idle(10);
    u_ctrl.issue(1'b1, CMD_MODE, BANK_MODE, 14'h0032, r);
    blen = 4;
    do_rd(2, 4, 1'b0);
    do_rd(9, 4, 1'b0);
    idle(10);
    repeat (20) @(negedge clk);
    check(exp_q.size(), 0);
    expect_err(0);
    // Illegal spacing, burst length eight
    chk_on = 1'b0;
    u_ctrl.issue(1'b1, CMD_MODE, BANK_MODE, 14'h0033, r);
    blen = 8;
    do_rd(0, 8, 1'b1);
    do_rd(8, 8, 1'b0);
    expect_err(1);
    do_rd(0, 8, 1'b0);
    u_ctrl.issue(1'b1, CMD_WRITE, 3'h1, 14'h0, r);
    expect_err(1);
    do_rd(0, 8, 1'b0);
    idle(4);
    u_ctrl.issue(1'b1, CMD_WRITE, 3'h1, 14'h0, r);
    expect_err(0);
    do_rd(0, 8, 1'b0);
    u_ctrl.issue(1'b1, CMD_PRECHARGE, 3'h2, 14'h0, r);
    expect_err(1);
    do_rd(0, 8, 1'b0);
    do_rd(8, 8, 1'b0);
    idle(4);
    u_ctrl.issue(1'b1, CMD_PRECHARGE, 3'h2, 14'h0, r);
    expect_err(0);
    do_wr(0, 8);
    do_rd(0, 8, 1'b0);
    expect_err(1);
    do_wr(0, 8);
    u_ctrl.issue(1'b1, CMD_PRECHARGE, 3'h1, 14'h0, r);
    expect_err(1);
    do_wr(0, 8);
    do_wr(8, 8);
    idle(10);
    u_ctrl.issue(1'b1, CMD_PRECHARGE, 3'h1, 14'h0, r);
    expect_err(0);
    // Self refresh entry and exit
    u_ctrl.issue(1'b1, CMD_ACTIVATE, 3'h2, 14'h0, r);
    idle(4);
    u_ctrl.issue(1'b0, CMD_REFRESH, 3'h0, 14'h0, r);
    expect_err(1);
    u_ctrl.issue(1'b1, 3'h7, 3'h0, 14'h0, r);
    u_ctrl.issue(1'b1, CMD_PRECHARGE, 3'h2, 14'h0400, r);
    on_die_termination <= 1'b1;
    idle(4);
    u_ctrl.issue(1'b0, CMD_REFRESH, 3'h0, 14'h0, r);
    expect_err(1);
    u_ctrl.issue(1'b1, 3'h7, 3'h0, 14'h0, r);
    on_die_termination <= 1'b0;
    idle(4);
    u_ctrl.issue(1'b0, CMD_REFRESH, 3'h0, 14'h0, r);
    expect_err(0);
    check(self_refresh, 1'b1);
    u_ctrl.issue(1'b1, CMD_READ, 3'h2, 14'h0, r);
    expect_err(1);
    u_ctrl.issue(1'b1, 3'h7, 3'h0, 14'h0, r);
    repeat (20) @(negedge clk);
    check(self_refresh, 1'b0);
    wrap_up();
  end
endmodule : tb
